// >>> rtl/sce_pkg.sv
package sce_pkg;
  localparam longint CLK_PERIOD_NS = 4;
  localparam longint PULSE_NS = 40_000_000;
  localparam longint QUIET_NS = 1_200_000_000;
  localparam longint PERIOD_LSB_NS = 2_560_000;
  localparam int PULSE_CYCLES = int'(PULSE_NS / CLK_PERIOD_NS);
  localparam int QUIET_CYCLES = int'(QUIET_NS / CLK_PERIOD_NS);
  localparam int PERIOD_LSB_CYCLES = int'(PERIOD_LSB_NS / CLK_PERIOD_NS);
  localparam int ALG_CYCLES = 8;
  localparam logic [7:0] DEB_STEPS_RESET = 8'h0A;
  localparam int SRC_CLR_BIT = 7;
  localparam int SRC_DET_BIT = 5;
  localparam int SRC_PER_BIT = 4;
  localparam int SRC_OVF_BIT = 3;
  localparam int SRC_INC_BIT = 2;

  typedef enum logic [0:0] {
    EXEC_IDLE = 1'b0,
    EXEC_RUN = 1'b1
  } sce_exec_state_type;

  typedef struct packed {
    logic step_engine_enable;
    logic step_engine_reinit;
    logic scaling_enable;
    logic [3:0] scaling_duration_threshold;
    logic [3:0] scaling_window_count;
    logic [7:0] debounce_step_count;
    logic classifier_enable;
    logic false_positive_reject_enable;
    logic event_latch_enable;
    logic [15:0] step_period_length;
  } sce_cfg_type;
endpackage

// >>> rtl/sce_supply_ctrl.sv
`timescale 1ns/1ps
module sce_supply_ctrl
  import sce_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Execution tracking
  input wire logic busy_next,
  input wire logic exec_start,
  input wire logic exec_end,
  // Configuration
  input wire logic scaling_enable,
  input wire logic [3:0] dur_threshold,
  input wire logic [3:0] window_count,
  // Result
  output logic supply_operating
);
  typedef struct packed {
    logic [3:0] dur;
    logic [3:0] wins;
    logic final_done;
    logic scaling_off;
    logic supply;
  } sce_sup_state_type;

  sce_sup_state_type st_reg, st_next;

  always_comb
  begin
    st_next = st_reg;
    if (exec_start)
      st_next.dur = 4'h0;
    else if (busy_next && st_reg.dur != 4'hF)
      st_next.dur = st_reg.dur + 4'h1;
    if (exec_end && !st_reg.final_done)
    begin
      if (st_reg.dur >= dur_threshold)
      begin
        st_next.scaling_off = 1'b1;
        st_next.final_done = 1'b1;
      end
      else if (window_count != 4'h0)
      begin
        st_next.wins = st_reg.wins + 4'h1;
        st_next.final_done = (st_reg.wins + 4'h1) == window_count;
      end
    end
    // Re-enabling starts a fresh evaluation
    if (!scaling_enable)
    begin
      st_next.wins = 4'h0;
      st_next.final_done = 1'b0;
      st_next.scaling_off = 1'b0;
    end
    st_next.supply = !scaling_enable || st_next.scaling_off || busy_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '{dur: 4'h0, wins: 4'h0, final_done: 1'b0,
                  scaling_off: 1'b0, supply: 1'b1};
    else
      st_reg <= st_next;
  end

  assign supply_operating = st_reg.supply;

  ////////////////////////////////////////////////////////////////////////////
  scaling_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    !scaling_enable |=> supply_operating)
    else $error("supply lowered with scaling disabled");
  over_thr_a: assert property (@(posedge clk) disable iff (!arst_n)
    exec_end && !st_reg.final_done && st_reg.dur >= dur_threshold
    && scaling_enable ##1 scaling_enable |-> ##1 supply_operating)
    else $error("scaling kept after over-threshold window");
endmodule

// >>> rtl/sce_engine.sv
`timescale 1ns/1ps
module sce_engine
  import sce_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES,
  parameter int QUIET_LEN = QUIET_CYCLES,
  parameter int PERIOD_LSB_LEN = PERIOD_LSB_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sample stream
  input wire logic data_ready,
  input wire logic step_hit,
  input wire logic walk_seen,
  // Configuration
  input wire sce_cfg_type cfg,
  // Host access
  input wire logic src_wr,
  input wire logic [7:0] src_wdata,
  input wire logic status_rd,
  input wire logic exec_status_rd,
  // Results
  output logic [15:0] step_total,
  output logic [7:0] pedometer_event_source,
  output logic exec_done_flag,
  output logic exec_overrun_flag,
  output logic step_irq,
  output logic supply_operating
);
  typedef struct packed {
    sce_exec_state_type fsm;
    logic [3:0] run_cnt;
    logic hit;
    logic walk;
    logic done;
    logic ovr;
    logic [15:0] total;
    logic [7:0] deb;
    logic armed;
    logic [31:0] quiet;
    logic [31:0] lsb_cnt;
    logic [15:0] per_cnt;
    logic per_step;
    logic [31:0] pulse;
    logic irq;
    logic [7:0] src;
  } sce_state_type;

  sce_state_type s_reg, s_next;
  logic exec_start, exec_end, counted;
  logic [16:0] sum;

  always_comb
  begin
    s_next = s_reg;
    exec_start = 1'b0;
    exec_end = 1'b0;
    counted = 1'b0;
    sum = 17'h00000;
    if (exec_status_rd)
      s_next.ovr = 1'b0;
    if (data_ready && s_reg.fsm == EXEC_RUN)
      s_next.ovr = 1'b1;
    case (s_reg.fsm)
      EXEC_IDLE:
      begin
        if (data_ready)
        begin
          exec_start = 1'b1;
          s_next.fsm = EXEC_RUN;
          s_next.run_cnt = 4'(ALG_CYCLES - 1);
          s_next.hit = step_hit;
          s_next.walk = walk_seen;
        end
      end
      EXEC_RUN:
      begin
        if (s_reg.run_cnt == 4'h0)
        begin
          exec_end = 1'b1;
          s_next.fsm = EXEC_IDLE;
        end
        else
          s_next.run_cnt = s_reg.run_cnt - 4'h1;
      end
      default:
        s_next.fsm = EXEC_IDLE;
    endcase
    s_next.done = s_next.fsm == EXEC_IDLE;

    if (s_reg.quiet >= 32'(QUIET_LEN - 1))
    begin
      s_next.deb = 8'h00;
      s_next.armed = 1'b0;
    end
    else
      s_next.quiet = s_reg.quiet + 32'h1;

    // step accepted only when enabled, and walking if classifier and false-positive reject are both on
    if (exec_end && cfg.step_engine_enable && s_reg.hit
        && (!(cfg.classifier_enable && cfg.false_positive_reject_enable)
            || s_reg.walk))
    begin
      s_next.quiet = 32'h0;
      if (s_reg.armed)
      begin
        counted = 1'b1;
        sum = {1'b0, s_reg.total} + 17'h00001;
      end
      else if (s_reg.deb + 8'h01 >= cfg.debounce_step_count)
      begin
        counted = 1'b1;
        s_next.armed = 1'b1;
        sum = {1'b0, s_reg.total} + {9'h000, s_reg.deb} + 17'h00001;
      end
      else
        s_next.deb = s_reg.deb + 8'h01;
    end
    if (counted)
    begin
      s_next.total = sum[15:0];
      s_next.per_step = 1'b1;
    end

    // event clearing by pulse end or status read
    if (s_reg.pulse != 32'h0)
      s_next.pulse = s_reg.pulse - 32'h1;
    if ((!cfg.event_latch_enable && s_reg.pulse == 32'h1)
        || (cfg.event_latch_enable && status_rd))
    begin
      s_next.irq = 1'b0;
      s_next.src[SRC_DET_BIT] = 1'b0;
      s_next.src[SRC_PER_BIT] = 1'b0;
      s_next.src[SRC_OVF_BIT] = 1'b0;
      s_next.src[SRC_INC_BIT] = 1'b0;
    end
    if (counted)
    begin
      s_next.src[SRC_DET_BIT] = 1'b1;
      // increment flag only without a period
      if (cfg.step_period_length == 16'h0000)
      begin
        s_next.src[SRC_INC_BIT] = 1'b1;
        s_next.irq = 1'b1;
        s_next.pulse = 32'(PULSE_LEN);
      end
      if (sum[16])
        s_next.src[SRC_OVF_BIT] = 1'b1;
    end

    if (cfg.step_period_length == 16'h0000)
    begin
      s_next.lsb_cnt = 32'h0;
      s_next.per_cnt = 16'h0000;
      s_next.per_step = 1'b0;
    end
    else if (s_reg.lsb_cnt >= 32'(PERIOD_LSB_LEN - 1))
    begin
      s_next.lsb_cnt = 32'h0;
      if (s_reg.per_cnt + 16'h0001 >= cfg.step_period_length)
      begin
        s_next.per_cnt = 16'h0000;
        s_next.per_step = 1'b0;
        if (s_reg.per_step || counted)
        begin
          s_next.src[SRC_PER_BIT] = 1'b1;
          s_next.irq = 1'b1;
          s_next.pulse = 32'(PULSE_LEN);
        end
      end
      else
        s_next.per_cnt = s_reg.per_cnt + 16'h0001;
    end
    else
      s_next.lsb_cnt = s_reg.lsb_cnt + 32'h1;

    // reinit clears algorithm state, not the total
    if (cfg.step_engine_reinit)
    begin
      s_next.deb = 8'h00;
      s_next.armed = 1'b0;
      s_next.quiet = 32'h0;
      s_next.lsb_cnt = 32'h0;
      s_next.per_cnt = 16'h0000;
      s_next.per_step = 1'b0;
    end

    if (s_reg.src[SRC_CLR_BIT])
    begin
      s_next.total = 16'h0000;
      s_next.src[SRC_CLR_BIT] = 1'b0;
    end
    if (src_wr && src_wdata[SRC_CLR_BIT])
      s_next.src[SRC_CLR_BIT] = 1'b1;
    s_next.src[6] = 1'b0;
    s_next.src[1:0] = 2'b00;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{fsm: EXEC_IDLE, run_cnt: 4'h0, hit: 1'b0, walk: 1'b0,
                 done: 1'b1, ovr: 1'b0, total: 16'h0000, deb: 8'h00,
                 armed: 1'b0, quiet: 32'h0, lsb_cnt: 32'h0,
                 per_cnt: 16'h0000, per_step: 1'b0, pulse: 32'h0,
                 irq: 1'b0, src: 8'h00};
    else
      s_reg <= s_next;
  end

  sce_supply_ctrl u_supply (
    .clk(clk),
    .arst_n(arst_n),
    .busy_next(s_next.fsm == EXEC_RUN),
    .exec_start(exec_start),
    .exec_end(exec_end),
    .scaling_enable(cfg.scaling_enable),
    .dur_threshold(cfg.scaling_duration_threshold),
    .window_count(cfg.scaling_window_count),
    .supply_operating(supply_operating)
  );

  assign step_total = s_reg.total;
  assign pedometer_event_source = s_reg.src;
  assign exec_done_flag = s_reg.done;
  assign exec_overrun_flag = s_reg.ovr;
  assign step_irq = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Busy span of one execution, ALG_CYCLES long
  sequence run_seq;
    !exec_done_flag [*8];
  endsequence

  exec_window_a: assert property (@(posedge clk) disable iff (!arst_n)
    exec_done_flag && data_ready |=> run_seq ##1 exec_done_flag)
    else $error("execution window length wrong");
  overrun_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    !exec_done_flag && data_ready |=> exec_overrun_flag)
    else $error("overrun not flagged");
  clear_self_a: assert property (@(posedge clk) disable iff (!arst_n)
    pedometer_event_source[SRC_CLR_BIT] |=> step_total == 16'h0000
    && !($past(src_wr) && $past(src_wdata[SRC_CLR_BIT]))
    |-> !pedometer_event_source[SRC_CLR_BIT])
    else $error("clear bit did not self-clear");
  zero_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
    pedometer_event_source[6] == 1'b0
    && pedometer_event_source[1:0] == 2'b00)
    else $error("reserved source bits nonzero");
  disabled_hold_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    !cfg.step_engine_enable && !pedometer_event_source[SRC_CLR_BIT]
    && !(src_wr && src_wdata[SRC_CLR_BIT]) ##1 !cfg.step_engine_enable
    |-> $stable(step_total))
    else $error("total changed while disabled");
  period_inc_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfg.step_period_length != 16'h0000 && $stable(cfg.step_period_length)
    && !pedometer_event_source[SRC_INC_BIT]
    |=> !pedometer_event_source[SRC_INC_BIT])
    else $error("increment flag raised with period set");
  irq_follows_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(pedometer_event_source[SRC_INC_BIT])
    && !$past(pedometer_event_source[SRC_CLR_BIT]) |-> step_irq
    && step_total != $past(step_total))
    else $error("step event without count change or irq");
  walk_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    exec_end && cfg.classifier_enable && cfg.false_positive_reject_enable
    && !s_reg.walk |-> !counted)
    else $error("counted while no walking");
endmodule

// >>> dv/sce_sample_src.sv
`timescale 1ns/1ps
module sce_sample_src
  import sce_pkg::*;
(
  // Clock
  input wire logic clk,
  // Sample stream
  output logic data_ready,
  output logic step_hit,
  output logic walk_seen
);
  initial
  begin
    data_ready = 1'b0;
    step_hit = 1'b0;
    walk_seen = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one sample per call
  task automatic send(input logic s, input logic w, input int gap);
    @(posedge clk);
    #1;
    data_ready = 1'b1;
    step_hit = s;
    walk_seen = w;
    @(posedge clk);
    #1;
    data_ready = 1'b0;
    // Stale qualifiers flip so nothing relies on them
    step_hit = ~s;
    walk_seen = ~w;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// >>> dv/step_counter_engine_test.sv
`timescale 1ns/1ps
module step_counter_engine_test
  import sce_pkg::*;
;
  logic clk;
  logic arst_n;
  logic data_ready;
  logic step_hit;
  logic walk_seen;
  sce_cfg_type cfg;
  logic src_wr;
  logic [7:0] src_wdata;
  logic status_rd;
  logic exec_status_rd;
  logic [15:0] step_total;
  logic [7:0] src;
  logic done;
  logic ovr;
  logic step_irq;
  logic supply;
  int failures;
  int tests_run;

  sce_engine #(.PULSE_LEN(20), .QUIET_LEN(200), .PERIOD_LSB_LEN(10)) u_dut (
    .clk(clk), .arst_n(arst_n), .data_ready(data_ready),
    .step_hit(step_hit), .walk_seen(walk_seen), .cfg(cfg),
    .src_wr(src_wr), .src_wdata(src_wdata), .status_rd(status_rd),
    .exec_status_rd(exec_status_rd), .step_total(step_total),
    .pedometer_event_source(src), .exec_done_flag(done),
    .exec_overrun_flag(ovr), .step_irq(step_irq),
    .supply_operating(supply)
  );

  sce_sample_src u_src (
    .clk(clk), .data_ready(data_ready), .step_hit(step_hit),
    .walk_seen(walk_seen)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Counts busy cycles; bounded so a stuck flag cannot hang the run
  task automatic wait_idle(output int n);
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic step_wait(input logic w);
    int n;
    u_src.send(1'b1, w, 0);
    wait_idle(n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("done", 16'h1, done);
    chk("supply", 16'h1, supply);
    chk("total", 16'h0, step_total);
    chk("source", 16'h0, src);
    $display("test reset finished");
  endtask

  task automatic t_exec;
    int n;
    u_src.send(1'b0, 1'b0, 0);
    wait_idle(n);
    chk("busy cycles", 16'(ALG_CYCLES), 16'(n));
    chk("overrun", 16'h0, ovr);
    $display("test exec finished");
  endtask

  task automatic t_steps;
    repeat (3) step_wait(1'b1);
    chk("total", 16'h3, step_total);
    chk("source", 16'h24, src);
    chk("irq", 16'h1, step_irq);
    repeat (30) @(posedge clk);
    #1;
    chk("irq pulse", 16'h0, step_irq);
    cfg.step_engine_enable = 1'b0;
    step_wait(1'b1);
    chk("total off", 16'h3, step_total);
    cfg.step_engine_enable = 1'b1;
    cfg.classifier_enable = 1'b1;
    cfg.false_positive_reject_enable = 1'b1;
    step_wait(1'b0);
    chk("total idle", 16'h3, step_total);
    cfg.event_latch_enable = 1'b1;
    step_wait(1'b1);
    chk("total walk", 16'h4, step_total);
    repeat (30) @(posedge clk);
    #1;
    chk("irq held", 16'h1, step_irq);
    status_rd = 1'b1;
    @(posedge clk);
    #1;
    status_rd = 1'b0;
    @(posedge clk);
    #1;
    chk("irq read", 16'h0, step_irq);
    repeat (250) @(posedge clk);
    step_wait(1'b1);
    chk("total quiet", 16'h4, step_total);
    $display("test steps finished");
  endtask

  task automatic t_overrun;
    int n;
    u_src.send(1'b0, 1'b0, 2);
    u_src.send(1'b0, 1'b0, 0);
    wait_idle(n);
    chk("overrun", 16'h1, ovr);
    exec_status_rd = 1'b1;
    @(posedge clk);
    #1;
    exec_status_rd = 1'b0;
    @(posedge clk);
    #1;
    chk("overrun read", 16'h0, ovr);
    $display("test overrun finished");
  endtask

  task automatic t_clear;
    @(posedge clk);
    #1;
    src_wr = 1'b1;
    src_wdata = 8'h80;
    @(posedge clk);
    #1;
    src_wr = 1'b0;
    chk("clear bit", 16'h1, src[SRC_CLR_BIT]);
    @(posedge clk);
    #1;
    chk("total", 16'h0, step_total);
    chk("clear back", 16'h0, src[SRC_CLR_BIT]);
    $display("test clear finished");
  endtask

  task automatic t_supply;
    int n;
    cfg.scaling_enable = 1'b1;
    cfg.scaling_duration_threshold = 4'hF;
    repeat (3) @(posedge clk);
    #1;
    chk("supply low", 16'h0, supply);
    u_src.send(1'b0, 1'b0, 1);
    #1;
    chk("supply run", 16'h1, supply);
    wait_idle(n);
    repeat (2) @(posedge clk);
    #1;
    chk("supply short", 16'h0, supply);
    cfg.scaling_duration_threshold = 4'h4;
    u_src.send(1'b0, 1'b0, 0);
    wait_idle(n);
    repeat (3) @(posedge clk);
    #1;
    chk("supply kept", 16'h1, supply);
    $display("test supply finished");
  endtask

  // One short window ends the comparison, so a later long one no longer keeps supply up
  task automatic t_window;
    int n;
    cfg.scaling_enable = 1'b0;
    @(posedge clk);
    #1;
    cfg.scaling_enable = 1'b1;
    cfg.scaling_window_count = 4'h1;
    cfg.scaling_duration_threshold = 4'hF;
    u_src.send(1'b0, 1'b0, 0);
    wait_idle(n);
    cfg.scaling_duration_threshold = 4'h4;
    u_src.send(1'b0, 1'b0, 0);
    wait_idle(n);
    repeat (2) @(posedge clk);
    #1;
    chk("supply decided", 16'h0, supply);
    $display("test window finished");
  endtask

  task automatic t_period;
    int n;
    cfg.event_latch_enable = 1'b0;
    cfg.debounce_step_count = 8'h01;
    cfg.step_period_length = 16'h0002;
    cfg.step_engine_reinit = 1'b1;
    @(posedge clk);
    #1;
    cfg.step_engine_reinit = 1'b0;
    step_wait(1'b1);
    chk("total period", 16'h1, step_total);
    chk("increment", 16'h0, src[SRC_INC_BIT]);
    n = 0;
    while (src[SRC_PER_BIT] !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("period flag", 16'h1, src[SRC_PER_BIT]);
    chk("period irq", 16'h1, step_irq);
    cfg.step_engine_reinit = 1'b1;
    @(posedge clk);
    #1;
    cfg.step_engine_reinit = 1'b0;
    chk("total reinit", 16'h1, step_total);
    $display("test period finished");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    tests_run = 0;
    arst_n = 1'b0;
    src_wr = 1'b0;
    src_wdata = 8'h00;
    status_rd = 1'b0;
    exec_status_rd = 1'b0;
    cfg = '0;
    cfg.step_engine_enable = 1'b1;
    cfg.debounce_step_count = 8'h03;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset;
    t_exec;
    t_steps;
    t_overrun;
    t_clear;
    t_supply;
    t_window;
    t_period;
    close_out;
  end

  // The tests need well under 2000 cycles
  initial
  begin
    #50_000;
    failures++;
    close_out;
  end
endmodule
